// file: rtl/baud_div_pkg.sv
// Purpose: Shared constants and types for the dual baud rate divider.
// Assumes: Master clock is the core clock, or external ticks on it.
// Notes:   Divisor table is indexed by the 4-bit rate code.
package baud_div_pkg;

    // Rate code width and count of selectable codes per channel
    localparam int RATE_W    = 4;
    localparam int NUM_CODES = 16;

    // Channel count and channel indices
    localparam int NUM_CH = 2;
    localparam int CH_RX  = 0;
    localparam int CH_TX  = 1;

    // Width of the feedback register that counts master ticks
    localparam int CNT_W = 15;

    // Output runs at this multiple of the nominal bit rate
    localparam int OVERSAMPLE = 16;

    // Core clock rate
    localparam int CORE_CLK_HZ = 10_000_000;

    // Rate code loaded at reset
    localparam logic [RATE_W-1:0] RATE_RESET = 4'h0;

    // Counter constants
    localparam logic [CNT_W-1:0] CNT_ONE  = 15'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;

    // Master-clock divisor for each rate code, code 0 first
    localparam logic [CNT_W-1:0] DIVISOR_TABLE [0:NUM_CODES-1] = '{
        15'h18C0, 15'h1080, 15'h0B40, 15'h0933,
        15'h0840, 15'h0420, 15'h0210, 15'h0108,
        15'h00B0, 15'h009E, 15'h0084, 15'h0058,
        15'h0042, 15'h002C, 15'h0021, 15'h0010
    };

    // Phase of one divider channel
    typedef enum logic [1:0] {
        PH_RESTART = 2'b00,
        PH_LOW     = 2'b01,
        PH_HIGH    = 2'b10
    } phase_t;

    // Rate programming of one channel
    typedef struct packed {
        logic              load;
        logic [RATE_W-1:0] rate;
    } chan_cfg_t;

    // Observable state of one channel
    typedef struct packed {
        logic              freq;
        logic              rise;
        logic              changed;
        logic [RATE_W-1:0] rate;
    } chan_stat_t;

endpackage

// file: rtl/dual_baud_rate_divider.sv
// Purpose: Dual programmable divider making receive and transmit
//          16x bit-rate clocks from one master clock.
// Assumes: All inputs synchronous to core_clk.
// Notes:   External master input is counted on its rising edges.
`timescale 1ns/100ps
module dual_baud_rate_divider (
    // Clock, reset and freeze
    input  wire logic                               core_clk,
    input  wire logic                               reset_n,
    input  wire logic                               clk_en,

    // Master clock source selection
    input  wire logic                               ext_clk_sel,
    input  wire logic                               master_clk_in_a,
    input  wire logic                               master_clk_in_b,

    // Receive rate programming
    input  wire logic [baud_div_pkg::RATE_W-1:0]    rx_rate_sel,
    input  wire logic                               rx_addr_load,

    // Transmit rate programming
    input  wire logic [baud_div_pkg::RATE_W-1:0]    tx_rate_sel,
    input  wire logic                               tx_addr_load,

    // Frequency outputs
    output logic                                    rx_freq_out,
    output logic                                    tx_freq_out,

    // Rising-edge markers of the outputs
    output logic                                    rx_freq_rise,
    output logic                                    tx_freq_rise,

    // Address register contents
    output logic [baud_div_pkg::RATE_W-1:0]         rx_rate_cur,
    output logic [baud_div_pkg::RATE_W-1:0]         tx_rate_cur,

    // Rate change markers
    output logic                                    rx_rate_changed,
    output logic                                    tx_rate_changed
);

    // ------------------------------------------------------------
    // Local declarations
    // ------------------------------------------------------------

    // Per-channel programming, packed for the channel loop
    baud_div_pkg::chan_cfg_t    cfg     [baud_div_pkg::NUM_CH];

    // Per-channel observable state
    baud_div_pkg::chan_stat_t   stat    [baud_div_pkg::NUM_CH];

    // Per-channel divisor chosen from the code table
    logic [baud_div_pkg::CNT_W-1:0] divisor [baud_div_pkg::NUM_CH];

    // Per-channel restart request
    logic                       restart [baud_div_pkg::NUM_CH];

    // Differential external level and its last value
    logic                       ext_level;
    logic                       ext_prev_q;

    // Source select seen last cycle, to spot a switch
    logic                       sel_prev_q;

    // One master period has elapsed this cycle
    logic                       master_tick;

    // Source switched this cycle
    logic                       src_switch;

    // ------------------------------------------------------------
    // Divisor lookup
    // ------------------------------------------------------------

    // Table lookup keeps all sixteen ratios in one place
    function automatic logic [baud_div_pkg::CNT_W-1:0] code_divisor(
        input logic [baud_div_pkg::RATE_W-1:0] code
    );
        code_divisor = baud_div_pkg::DIVISOR_TABLE[code];
    endfunction

    // ------------------------------------------------------------
    // Gather channel programming
    // ------------------------------------------------------------

    // Receive channel inputs
    assign cfg[baud_div_pkg::CH_RX] = '{
        load: rx_addr_load,
        rate: rx_rate_sel
    };

    // Transmit channel inputs
    assign cfg[baud_div_pkg::CH_TX] = '{
        load: tx_addr_load,
        rate: tx_rate_sel
    };

    // ------------------------------------------------------------
    // Master clock source
    // ------------------------------------------------------------

    // The two master pins form a pair: pin a high and pin b
    // low means a high level. For a cascade, drive pin a
    // from a preceding output and hold pin b low.
    assign ext_level = master_clk_in_a & ~master_clk_in_b;

    // Remember the last external level for edge detection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_prev_q <= 1'b0;
        end else if (clk_en) begin
            ext_prev_q <= ext_level;
        end
    end

    // Remember the source select to catch a switch of source
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_prev_q <= 1'b0;
        end else if (clk_en) begin
            sel_prev_q <= ext_clk_sel;
        end
    end

    // Internal source ticks every core cycle; the external source
    // ticks once per rising edge, so an input faster than half the
    // core rate loses edges. This is what lets one output serve as
    // the master of a following divider.
    always_comb begin
        if (ext_clk_sel) begin
            master_tick = ext_level & ~ext_prev_q;
        end else begin
            master_tick = 1'b1;
        end
    end

    // A switch of source leaves the phase meaningless; restart both
    assign src_switch = ext_clk_sel ^ sel_prev_q;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------

    // Two identical channels, each with its own address register
    // and divider, sharing only the master tick and the source-switch restart. Nothing one
    // channel does reaches the other.
    for (genvar ch = 0; ch < baud_div_pkg::NUM_CH; ch++) begin : g_chan

        // Address register: level strobe, may be tied high
        rate_addr_reg u_addr (
            .core_clk   (core_clk),
            .reset_n    (reset_n),
            .clk_en     (clk_en),
            .cfg        (cfg[ch]),
            .rate_q     (stat[ch].rate),
            .changed_q  (stat[ch].changed)
        );

        // Ratio follows the held code, not the raw pins
        assign divisor[ch] = code_divisor(stat[ch].rate);

        // Restart on a new ratio or a new source
        assign restart[ch] = stat[ch].changed | src_switch;

        // Feedback register dividing the master ticks
        freq_divider u_div (
            .core_clk   (core_clk),
            .reset_n    (reset_n),
            .clk_en     (clk_en),
            .tick       (master_tick),
            .restart    (restart[ch]),
            .divisor    (divisor[ch]),
            .freq_q     (stat[ch].freq),
            .rise_q     (stat[ch].rise)
        );

    end

    // ------------------------------------------------------------
    // Outputs, all straight from channel flip-flops
    // ------------------------------------------------------------

    // Sixteen-times clocks for the receiver and transmitter
    assign rx_freq_out     = stat[baud_div_pkg::CH_RX].freq;
    assign tx_freq_out     = stat[baud_div_pkg::CH_TX].freq;

    // Rising-edge markers, handy for logic on core_clk
    assign rx_freq_rise    = stat[baud_div_pkg::CH_RX].rise;
    assign tx_freq_rise    = stat[baud_div_pkg::CH_TX].rise;

    // Held codes, readable back by the controlling logic
    assign rx_rate_cur     = stat[baud_div_pkg::CH_RX].rate;
    assign tx_rate_cur     = stat[baud_div_pkg::CH_TX].rate;

    // Rate change markers
    assign rx_rate_changed = stat[baud_div_pkg::CH_RX].changed;
    assign tx_rate_changed = stat[baud_div_pkg::CH_TX].changed;

endmodule // dual_baud_rate_divider

// file: rtl/freq_divider.sv
// Purpose: Programmable divider producing one 16x bit-rate clock.
// Assumes: tick marks one master clock period; restart is a pulse.
// Notes:   Low half gets the extra tick of an odd divisor.
`timescale 1ns/100ps
module freq_divider (
    // Clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               reset_n,
    input  wire logic                               clk_en,
    // Control
    input  wire logic                               tick,
    input  wire logic                               restart,
    input  wire logic [baud_div_pkg::CNT_W-1:0]     divisor,
    // Output
    output logic                                    freq_q,
    output logic                                    rise_q
);

    // Phase, remaining ticks in phase
    baud_div_pkg::phase_t                   phase_q;
    logic [baud_div_pkg::CNT_W-1:0]         cnt_q;
    logic [baud_div_pkg::CNT_W-1:0]         high_len;
    logic [baud_div_pkg::CNT_W-1:0]         low_len;

    // Split the period into two halves
    assign high_len = divisor >> 1;
    assign low_len  = divisor - high_len;

    // Feedback register: reloads itself at the end of each half
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= baud_div_pkg::PH_RESTART;
            cnt_q   <= baud_div_pkg::CNT_ZERO;
            freq_q  <= 1'b0;
            rise_q  <= 1'b0;
        end else if (clk_en) begin
            rise_q <= 1'b0;
            if (restart) begin
                // New ratio or new source: drop low, start a full low half
                phase_q <= baud_div_pkg::PH_RESTART;
                freq_q  <= 1'b0;
                cnt_q   <= low_len - baud_div_pkg::CNT_ONE;
            end else if (tick) begin
                case (phase_q)
                    baud_div_pkg::PH_RESTART: begin
                        // First tick of the fresh low half
                        phase_q <= baud_div_pkg::PH_LOW;
                        cnt_q   <= low_len - baud_div_pkg::CNT_ONE
                                   - baud_div_pkg::CNT_ONE;
                    end
                    baud_div_pkg::PH_LOW: begin
                        if (cnt_q == baud_div_pkg::CNT_ZERO) begin
                            phase_q <= baud_div_pkg::PH_HIGH;
                            freq_q  <= 1'b1;
                            rise_q  <= 1'b1;
                            cnt_q   <= high_len - baud_div_pkg::CNT_ONE;
                        end else begin
                            cnt_q <= cnt_q - baud_div_pkg::CNT_ONE;
                        end
                    end
                    baud_div_pkg::PH_HIGH: begin
                        if (cnt_q == baud_div_pkg::CNT_ZERO) begin
                            phase_q <= baud_div_pkg::PH_LOW;
                            freq_q  <= 1'b0;
                            cnt_q   <= low_len - baud_div_pkg::CNT_ONE;
                        end else begin
                            cnt_q <= cnt_q - baud_div_pkg::CNT_ONE;
                        end
                    end
                    default: begin
                        phase_q <= baud_div_pkg::PH_RESTART;
                        freq_q  <= 1'b0;
                        cnt_q   <= low_len - baud_div_pkg::CNT_ONE;
                    end
                endcase
            end
        end
    end

endmodule // freq_divider

// file: rtl/rate_addr_reg.sv
// Purpose: Rate address register of one channel.
// Assumes: Load strobe is synchronous to core_clk.
// Notes:   A strobe tied high makes the register follow its inputs.
`timescale 1ns/100ps
module rate_addr_reg (
    // Clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               reset_n,
    input  wire logic                               clk_en,
    // Programming
    input  wire baud_div_pkg::chan_cfg_t            cfg,
    // State
    output logic [baud_div_pkg::RATE_W-1:0]         rate_q,
    output logic                                    changed_q
);

    // Capture the code on every enabled cycle with the strobe high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_q <= baud_div_pkg::RATE_RESET;
        end else if (clk_en && cfg.load) begin
            rate_q <= cfg.rate;
        end
    end

    // One-cycle flag when a load actually changes the code
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            changed_q <= 1'b0;
        end else if (clk_en) begin
            changed_q <= cfg.load && (cfg.rate != rate_q);
        end
    end

endmodule // rate_addr_reg

// file: test/dual_baud_rate_divider_sva.sv
// Purpose: Port-level checks of the dual baud rate divider.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/100ps
module baud_div_chk (
    // Clock and reset
    input wire logic                            core_clk,
    input wire logic                            reset_n,
    input wire logic                            clk_en,
    // Programming
    input wire logic [baud_div_pkg::RATE_W-1:0] rx_rate_sel,
    input wire logic                            rx_addr_load,
    input wire logic [baud_div_pkg::RATE_W-1:0] tx_rate_sel,
    input wire logic                            tx_addr_load,
    // Outputs
    input wire logic                            rx_freq_out,
    input wire logic                            tx_freq_out,
    input wire logic                            rx_freq_rise,
    input wire logic                            tx_freq_rise,
    input wire logic [baud_div_pkg::RATE_W-1:0] rx_rate_cur,
    input wire logic [baud_div_pkg::RATE_W-1:0] tx_rate_cur,
    input wire logic                            rx_rate_changed,
    input wire logic                            tx_rate_changed
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Shortest divisor keeps the restarted low half at least 8 ticks
    sequence s_rx_low; !rx_freq_out [*8]; endsequence
    sequence s_tx_low; !tx_freq_out [*8]; endsequence

    property p_rx_load; rx_addr_load && clk_en |=> rx_rate_cur == $past(rx_rate_sel); endproperty
    property p_tx_load; tx_addr_load && clk_en |=> tx_rate_cur == $past(tx_rate_sel); endproperty
    property p_rx_hold; !(rx_addr_load && clk_en) |=> $stable(rx_rate_cur); endproperty
    property p_tx_hold; !(tx_addr_load && clk_en) |=> $stable(tx_rate_cur); endproperty
    property p_rx_restart; rx_rate_changed |=> s_rx_low; endproperty
    property p_tx_restart; tx_rate_changed |=> s_tx_low; endproperty
    // A frozen cycle holds the marker as it stands, so only judge after a live edge
    property p_rx_rise; $past(clk_en) |-> rx_freq_rise == $rose(rx_freq_out); endproperty
    property p_tx_rise; $past(clk_en) |-> tx_freq_rise == $rose(tx_freq_out); endproperty

    a_rx_load: assert property (p_rx_load) else $error("rx code not loaded");
    a_tx_load: assert property (p_tx_load) else $error("tx code not loaded");
    a_rx_hold: assert property (p_rx_hold) else $error("rx code moved");
    a_tx_hold: assert property (p_tx_hold) else $error("tx code moved");
    a_rx_restart: assert property (p_rx_restart) else $error("rx runt pulse");
    a_tx_restart: assert property (p_tx_restart) else $error("tx runt pulse");
    a_rx_rise: assert property (p_rx_rise) else $error("rx rise marker");
    a_tx_rise: assert property (p_tx_rise) else $error("tx rise marker");
endmodule // baud_div_chk

bind dual_baud_rate_divider baud_div_chk i_chk (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .rx_rate_sel(rx_rate_sel), .rx_addr_load(rx_addr_load),
    .tx_rate_sel(tx_rate_sel), .tx_addr_load(tx_addr_load), .rx_freq_out(rx_freq_out),
    .tx_freq_out(tx_freq_out), .rx_freq_rise(rx_freq_rise), .tx_freq_rise(tx_freq_rise),
    .rx_rate_cur(rx_rate_cur), .tx_rate_cur(tx_rate_cur),
    .rx_rate_changed(rx_rate_changed), .tx_rate_changed(tx_rate_changed));

// file: test/dual_baud_rate_divider_tb.sv
// Purpose: Self-checking bench of the dual baud rate divider.
// Assumes: Inputs change 10 ns after the rising clock edge.
// Notes:   Periods are measured by two sink models.
`timescale 1ns/100ps
module dual_baud_rate_divider_tb;
    // Divisors expected for codes 0 to 15
    localparam logic [15:0] DIV_EXP [0:15] = '{16'h18C0, 16'h1080, 16'h0B40, 16'h0933,
        16'h0840, 16'h0420, 16'h0210, 16'h0108, 16'h00B0, 16'h009E, 16'h0084, 16'h0058,
        16'h0042, 16'h002C, 16'h0021, 16'h0010};
    logic        core_clk, reset_n, clk_en, ext_clk_sel, ext_run, ext_div;
    logic        master_clk_in_a, master_clk_in_b, rx_addr_load, tx_addr_load;
    logic [3:0]  rx_rate_sel, tx_rate_sel, rx_rate_cur, tx_rate_cur, rs, ts;
    logic        rx_freq_out, tx_freq_out, rx_rate_changed, tx_rate_changed;
    logic [15:0] rx_per, rx_hi, rx_edges, tx_per, tx_hi, tx_edges;
    int          fail_count, checks_done;

    dual_baud_rate_divider i_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .ext_clk_sel(ext_clk_sel), .master_clk_in_a(master_clk_in_a),
        .master_clk_in_b(master_clk_in_b), .rx_rate_sel(rx_rate_sel),
        .rx_addr_load(rx_addr_load), .tx_rate_sel(tx_rate_sel), .tx_addr_load(tx_addr_load),
        .rx_freq_out(rx_freq_out), .tx_freq_out(tx_freq_out), .rx_freq_rise(),
        .tx_freq_rise(), .rx_rate_cur(rx_rate_cur), .tx_rate_cur(tx_rate_cur),
        .rx_rate_changed(rx_rate_changed), .tx_rate_changed(tx_rate_changed));
    rate_clk_sink i_rx_sink (.core_clk(core_clk), .reset_n(reset_n), .freq(rx_freq_out),
        .period_q(rx_per), .high_q(rx_hi), .edges_q(rx_edges));
    rate_clk_sink i_tx_sink (.core_clk(core_clk), .reset_n(reset_n), .freq(tx_freq_out),
        .period_q(tx_per), .high_q(tx_hi), .edges_q(tx_edges));

    // Clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // External master level: one rise every 4 core cycles, above the 2-cycle minimum
    always @(posedge core_clk) begin
        #10;
        if (ext_run) begin
            ext_div = ~ext_div;
            if (ext_div) master_clk_in_a = ~master_clk_in_a;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Two fresh rises on both channels; bounded so a dead divider ends the run
    task automatic wait_rises;
        logic [15:0] r0, t0;
        int          n;
        r0 = rx_edges;
        t0 = tx_edges;
        n  = 0;
        while ((rx_edges - r0 < 16'h0002 || tx_edges - t0 < 16'h0002) && n < 40000) begin
            step(1);
            n++;
        end
        if (n >= 40000) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // Main sequence
    initial begin
        {reset_n, ext_clk_sel, ext_run, ext_div, master_clk_in_a, master_clk_in_b} = '0;
        {rx_addr_load, tx_addr_load} = '0;
        clk_en = 1'b1;
        rx_rate_sel = 4'h5;
        tx_rate_sel = 4'h0;
        fail_count = 0;
        checks_done = 0;
        step(10);
        chk({12'h000, rx_rate_cur}, 16'h0000);
        chk({15'h0000, rx_freq_out}, 16'h0000);
        reset_n = 1'b1;
        step(1);
        // Strobe a new receive code, then keep the strobe up on the same code
        rx_addr_load = 1'b1;
        step(1);
        chk({12'h000, rx_rate_cur}, 16'h0005);
        chk({15'h0000, rx_rate_changed}, 16'h0001);
        chk({12'h000, tx_rate_cur}, 16'h0000);
        step(1);
        chk({15'h0000, rx_rate_changed}, 16'h0000);
        // Frozen clock ignores the strobe, then strobe tied high tracks
        clk_en = 1'b0;
        rx_rate_sel = 4'h9;
        step(1);
        chk({12'h000, rx_rate_cur}, 16'h0005);
        clk_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            step(1);
            chk({12'h000, rx_rate_cur}, {12'h000, rx_rate_sel});
            rx_rate_sel = rx_rate_sel + 4'h2;
        end
        // Drop the strobe and let an edge pass before the next load
        rx_addr_load = 1'b0;
        step(1);
        // Every code once, channels on different codes at once
        for (int c = 0; c < 8; c++) begin
            rs = c[0] ? 4'(15 - c) : 4'(c);
            ts = 4'hF - rs;
            rx_rate_sel = rs;
            tx_rate_sel = ts;
            {rx_addr_load, tx_addr_load} = 2'b11;
            step(1);
            {rx_addr_load, tx_addr_load} = 2'b00;
            chk({12'h000, tx_rate_cur}, {12'h000, ts});
            chk({14'h0000, rx_rate_changed, tx_rate_changed}, 16'h0003);
            step(3);
            wait_rises();
            chk(rx_per, DIV_EXP[rs]);
            chk(rx_hi, DIV_EXP[rs] >> 1);
            chk(tx_per, DIV_EXP[ts]);
            chk(tx_hi, DIV_EXP[ts] >> 1);
        end
        // External master source: one tick per 4 core cycles stretches both periods
        ext_run = 1'b1;
        ext_clk_sel = 1'b1;
        step(3);
        wait_rises();
        chk(rx_per, DIV_EXP[rs] << 2);
        chk(rx_hi, (DIV_EXP[rs] >> 1) << 2);
        chk(tx_per, DIV_EXP[ts] << 2);
        chk(tx_hi, (DIV_EXP[ts] >> 1) << 2);
        report_and_stop();
    end
endmodule // dual_baud_rate_divider_tb

// file: test/rate_clk_sink.sv
// Purpose: Far-side consumer of one 16x clock, as a serial unit sees it.
// Assumes: The clock is sampled on core_clk; one sample per core cycle.
// Notes:   Reports last full period, last high width and a rise count.
`timescale 1ns/100ps
module rate_clk_sink (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Watched 16x clock
    input  wire logic        freq,
    // Measurements
    output logic [15:0]      period_q,
    output logic [15:0]      high_q,
    output logic [15:0]      edges_q
);
    logic        last_q;  // Previous sample of the clock
    logic [15:0] cnt_q;   // Cycles since the last rise
    logic [15:0] hcnt_q;  // Cycles high so far

    // Edge detection on our own samples, not the design's markers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            {last_q, cnt_q, hcnt_q} <= '0;
            {period_q, high_q, edges_q} <= '0;
        end else begin
            last_q <= freq;
            hcnt_q <= freq ? hcnt_q + 16'h0001 : 16'h0000;
            // Rise: one sixteenth of a bit time for the serial unit
            if (freq && !last_q) begin
                period_q <= cnt_q;
                cnt_q    <= 16'h0001;
                edges_q  <= edges_q + 16'h0001;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
            // Fall: the high half just ended
            if (!freq && last_q) begin
                high_q <= hcnt_q;
            end
        end
    end
endmodule // rate_clk_sink
